// file: verilog/thermal_alert_config_logic.sv
// Control register, limit registers and alert pin logic of a temperature sensor.
// Assumes a serial front end on link_clk_in issues register requests and a
// converter on clk_in delivers samples; rst_in is the internal power-on reset.
//
// How it works
// - Control bits 15 to 11 read zero; writes to them are dropped.
// - Bits 10:9 pick hysteresis: none, 1.5, 3 or 6 degrees for all limits.
// - Upper and critical flags hold until at or below limit minus hysteresis; lower flag sets below it, clears at limit.
// - Hysteresis field is frozen while either lock bit is set.
// - Shutdown bit stops conversion, alerts and temperature updates.
// - Shutdown cannot be set while locked, but can always be cleared.
// - Register access keeps working during shutdown.
// - Critical lock bit freezes the critical limit until power-on reset.
// - Window lock bit freezes upper and lower limits until power-on reset.
// - Clear bit reads zero, self-clears, releases a latched alert.
// - Status bit reads one while the alert pin is asserted.
// - Alert enable bit gates the alert pin.
// - Critical-only bit limits alerts to critical; frozen by window lock.
// - Polarity bit chooses the asserted pin level, low or high.
// - Mode bit selects comparator or interrupt behaviour.
// - Enable, polarity and mode bits are frozen while either lock is set.
// - Limits and temperature are two's complement, sign at B12, B2 is 0.25.
// - Limits keep quarter-degree granularity; finer bits only in temperature.
// - Comparisons use B12 through B2; reads show all temperature bits.
// - Upper limit crossings raise the alert; register locked by window lock.
// - Lower limit crossings raise the alert; register locked by window lock.
// - Above critical the alert holds until at or below limit minus hysteresis.
`timescale 1ns/10ps
`default_nettype none

`include "thermal_alert_regs.svh"

module thermal_alert_config_logic
(
  // Core clock and power-on reset
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  // Serial link side register port
  input  wire logic                          link_clk_in,
  input  wire logic                          link_rst_in,
  input  wire logic                          link_req_in,
  input  wire logic                          link_write_in,
  input  wire logic [3:0]                    link_addr_in,
  input  wire thermal_alert_pkg::reg_word_t  link_wdata_in,
  output logic                               link_busy_out,
  output logic                               link_rvalid_out,
  output thermal_alert_pkg::reg_word_t       link_rdata_out,
  // Converter
  input  wire logic [12:0]                   temp_in,
  input  wire logic                          temp_valid_in,
  output logic                               conv_enable_out,
  // Alert pin
  output logic                               alert_out
);
  import thermal_alert_pkg::*;

  // Link domain state
  link_state_t  link_state;
  logic         req_toggle;
  logic         req_write;
  logic [3:0]   req_addr;
  reg_word_t    req_wdata;
  logic         ack_meta;
  logic         ack_sync;

  // Core domain crossing state
  logic         req_meta;
  logic         req_sync;
  logic         req_seen;
  logic         ack_toggle;
  reg_word_t    resp_data;
  logic         req_new;

  // Control register fields
  hyst_sel_t    hysteresis_select;
  logic         sensor_shutdown;
  logic         critical_limit_lock;
  logic         window_limit_lock;
  logic         alert_enable;
  logic         critical_only_select;
  logic         alert_polarity;
  logic         alert_mode;
  logic         any_lock;

  // Limits and temperature
  reg_word_t    upper_window_limit;
  reg_word_t    lower_window_limit;
  reg_word_t    critical_limit;
  logic [12:0]  temp_data;
  logic         sample;
  logic [4:0]   hyst_steps;
  logic         above_upper;
  logic         below_lower;
  logic         above_critical;

  // Alert state
  logic         cond_now;
  logic [2:0]   flags_prev;
  logic         flag_event;
  logic         irq_latch;
  logic         clear_req;
  logic         alert_asserted_flag;
  logic         ctrl_write;

  // Quarter-degree steps for a hysteresis code
  function automatic logic [4:0] hyst_counts(input hyst_sel_t sel);
    unique case (sel)
      HYST_OFF: hyst_counts = `TA_HYST_NONE;
      HYST_1P5: hyst_counts = `TA_HYST_1P5;
      HYST_3P0: hyst_counts = `TA_HYST_3P0;
      HYST_6P0: hyst_counts = `TA_HYST_6P0;
    endcase
  endfunction

  // Write strobe for a register pointer
  function automatic logic wr_hit(input logic [3:0] addr, input logic [3:0] off);
    wr_hit = req_new && req_write && (addr == off);
  endfunction

  // Link side: take a request when idle, hold it until the core answers
  always_ff @(posedge link_clk_in)
  begin
    if (link_rst_in)
    begin
      link_state <= LINK_IDLE;
      req_toggle <= 1'b0;
      req_write  <= 1'b0;
      req_addr   <= 4'h0;
      req_wdata  <= 16'h0000;
    end
    else
    begin
      unique case (link_state)
        LINK_IDLE:
        begin
          if (link_req_in)
          begin
            req_write  <= link_write_in;
            req_addr   <= link_addr_in;
            req_wdata  <= link_wdata_in;
            req_toggle <= ~req_toggle;
            link_state <= LINK_WAIT;
          end
        end
        LINK_WAIT:
        begin
          if (ack_sync == req_toggle)
            link_state <= LINK_IDLE;
        end
      endcase
    end
  end

  // Link side: bring the answer toggle over the crossing
  always_ff @(posedge link_clk_in)
  begin
    if (link_rst_in)
    begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end
    else
    begin
      ack_meta <= ack_toggle;
      ack_sync <= ack_meta;
    end
  end

  // Link side: capture read data once the answer is seen
  always_ff @(posedge link_clk_in)
  begin
    if (link_rst_in)
    begin
      link_rvalid_out <= 1'b0;
      link_rdata_out  <= 16'h0000;
    end
    else
    begin
      link_rvalid_out <= 1'b0;
      if ((link_state == LINK_WAIT) && (ack_sync == req_toggle))
      begin
        link_rvalid_out <= ~req_write;
        if (!req_write)
          link_rdata_out <= resp_data;
      end
    end
  end

  assign link_busy_out = (link_state == LINK_WAIT);

  // Core side: synchronise the request toggle; fields are stable while it differs
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_seen <= 1'b0;
    end
    else
    begin
      req_meta <= req_toggle;
      req_sync <= req_meta;
      req_seen <= req_sync;
    end
  end

  // Accesses are served in every mode, shutdown included
  assign req_new    = req_sync ^ req_seen;
  assign ctrl_write = wr_hit(req_addr, `TA_OFF_CONTROL);
  assign any_lock   = critical_limit_lock | window_limit_lock;

  // Control register fields; lock rules gate each write
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      hysteresis_select    <= HYST_OFF;
      sensor_shutdown      <= 1'b0;
      critical_limit_lock  <= 1'b0;
      window_limit_lock    <= 1'b0;
      alert_enable         <= 1'b0;
      critical_only_select <= 1'b0;
      alert_polarity       <= 1'b0;
      alert_mode           <= 1'b0;
    end
    else if (ctrl_write)
    begin
      if (!any_lock)
        hysteresis_select <= hyst_sel_t'(req_wdata[`TA_HYST_HI:`TA_HYST_LO]);
      if (!req_wdata[`TA_SHUTDOWN_BIT] || !any_lock)
        sensor_shutdown <= req_wdata[`TA_SHUTDOWN_BIT];
      if (req_wdata[`TA_CRIT_LOCK_BIT])
        critical_limit_lock <= 1'b1;
      if (req_wdata[`TA_WIN_LOCK_BIT])
        window_limit_lock <= 1'b1;
      if (!any_lock)
      begin
        alert_enable   <= req_wdata[`TA_ENABLE_BIT];
        alert_polarity <= req_wdata[`TA_POLARITY_BIT];
        alert_mode     <= req_wdata[`TA_MODE_BIT];
      end
      if (!window_limit_lock)
        critical_only_select <= req_wdata[`TA_CRIT_ONLY_BIT];
    end
  end

  // Clear request lives one cycle and only in interrupt mode
  assign clear_req = ctrl_write && req_wdata[`TA_CLEAR_BIT] && alert_mode;

  // Limit registers keep only B12..B2; locks refuse writes
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      upper_window_limit <= `TA_LIMIT_RESET;
      lower_window_limit <= `TA_LIMIT_RESET;
      critical_limit     <= `TA_LIMIT_RESET;
    end
    else
    begin
      if (wr_hit(req_addr, `TA_OFF_UPPER) && !window_limit_lock)
        upper_window_limit <= req_wdata & `TA_LIMIT_MASK;
      if (wr_hit(req_addr, `TA_OFF_LOWER) && !window_limit_lock)
        lower_window_limit <= req_wdata & `TA_LIMIT_MASK;
      if (wr_hit(req_addr, `TA_OFF_CRITICAL) && !critical_limit_lock)
        critical_limit <= req_wdata & `TA_LIMIT_MASK;
    end
  end

  // Conversion runs only out of shutdown; samples are frozen in shutdown
  assign conv_enable_out = ~sensor_shutdown;
  assign sample          = temp_valid_in & ~sensor_shutdown;

  // Temperature data holds every bit the converter delivers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      temp_data <= 13'h0000;
    else if (sample)
      temp_data <= temp_in;
  end

  assign hyst_steps = hyst_counts(hysteresis_select);

  // Comparators see only B12..B2 of the sample and the limits
  thermal_threshold u_upper
  (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .sample_in     (sample),
    .below_mode_in (1'b0),
    .temp_in       (temp_in[12:2]),
    .limit_in      (upper_window_limit[12:2]),
    .hyst_in       (hyst_steps),
    .flag_out      (above_upper)
  );

  thermal_threshold u_lower
  (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .sample_in     (sample),
    .below_mode_in (1'b1),
    .temp_in       (temp_in[12:2]),
    .limit_in      (lower_window_limit[12:2]),
    .hyst_in       (hyst_steps),
    .flag_out      (below_lower)
  );

  thermal_threshold u_critical
  (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .sample_in     (sample),
    .below_mode_in (1'b0),
    .temp_in       (temp_in[12:2]),
    .limit_in      (critical_limit[12:2]),
    .hyst_in       (hyst_steps),
    .flag_out      (above_critical)
  );

  // Out-of-limit condition after the critical-only filter
  assign cond_now = above_critical | (~critical_only_select & (above_upper | below_lower));

  // Any crossing of a selected limit, either direction, is an interrupt event
  assign flag_event = (flags_prev[2] ^ above_critical) |
                      (~critical_only_select & ((flags_prev[1] ^ above_upper) |
                                                (flags_prev[0] ^ below_lower)));

  // Previous flags for crossing detection
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      flags_prev <= 3'b000;
    else
      flags_prev <= {above_critical, above_upper, below_lower};
  end

  // Interrupt latch: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      irq_latch <= 1'b0;
    else if (flag_event && !sensor_shutdown && alert_enable)
      irq_latch <= 1'b1;
    else if (clear_req || !alert_mode)
      irq_latch <= 1'b0;
  end

  // Asserted state of the pin, before polarity
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      alert_asserted_flag <= 1'b0;
    else if (sensor_shutdown || !alert_enable)
      alert_asserted_flag <= 1'b0;
    else if (!alert_mode)
      alert_asserted_flag <= cond_now;
    else
      alert_asserted_flag <= irq_latch | above_critical;
  end

  // Pin level from polarity
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      alert_out <= 1'b1;
    else
      alert_out <= alert_polarity ? alert_asserted_flag : ~alert_asserted_flag;
  end

  // Read answer; unmapped pointers read zero
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      resp_data  <= 16'h0000;
      ack_toggle <= 1'b0;
    end
    else if (req_new)
    begin
      ack_toggle <= ~ack_toggle;
      resp_data  <= 16'h0000;
      unique case (req_addr)
        `TA_OFF_CONTROL:
        begin
          resp_data <= {5'h00,
                        hysteresis_select,
                        sensor_shutdown,
                        critical_limit_lock,
                        window_limit_lock,
                        1'b0,
                        alert_asserted_flag,
                        alert_enable,
                        critical_only_select,
                        alert_polarity,
                        alert_mode};
        end
        `TA_OFF_UPPER:       resp_data <= upper_window_limit;
        `TA_OFF_LOWER:       resp_data <= lower_window_limit;
        `TA_OFF_CRITICAL:    resp_data <= critical_limit;
        `TA_OFF_TEMPERATURE:
        begin
          resp_data <= {above_critical, above_upper, below_lower, temp_data};
        end
        default:             resp_data <= 16'h0000;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: pkg/thermal_alert_regs.svh
// Offsets, field positions, reset values and hysteresis counts of the
// thermal alert block. Included by the package, the block top, the checker and the host model.
`ifndef THERMAL_ALERT_REGS_SVH
`define THERMAL_ALERT_REGS_SVH

// Register pointer values
`define TA_ADDR_W            4
`define TA_OFF_CONTROL       4'h1
`define TA_OFF_UPPER         4'h2
`define TA_OFF_LOWER         4'h3
`define TA_OFF_CRITICAL      4'h4
`define TA_OFF_TEMPERATURE   4'h5

// Control register field positions
`define TA_HYST_HI           10
`define TA_HYST_LO           9
`define TA_SHUTDOWN_BIT      8
`define TA_CRIT_LOCK_BIT     7
`define TA_WIN_LOCK_BIT      6
`define TA_CLEAR_BIT         5
`define TA_ASSERTED_BIT      4
`define TA_ENABLE_BIT        3
`define TA_CRIT_ONLY_BIT     2
`define TA_POLARITY_BIT      1
`define TA_MODE_BIT          0

// Temperature data flag positions
`define TA_TEMP_CRIT_BIT     15
`define TA_TEMP_HIGH_BIT     14
`define TA_TEMP_LOW_BIT      13

// Reset values and masks
`define TA_CONTROL_RESET     16'h0000
`define TA_LIMIT_RESET       16'h0000
`define TA_LIMIT_MASK        16'h1ffc
`define TA_TEMP_MASK         16'h1fff

// Hysteresis in quarter-degree steps (1.5, 3 and 6 degrees)
`define TA_HYST_NONE         5'h00
`define TA_HYST_1P5          5'h06
`define TA_HYST_3P0          5'h0c
`define TA_HYST_6P0          5'h18

`endif

// file: pkg/thermal_alert_pkg.sv
// Types shared by the thermal alert design files.
// Assumes thermal_alert_regs.svh is found on the include path.
`include "thermal_alert_regs.svh"

package thermal_alert_pkg;

  // Link-side request sequencer, one-hot
  typedef enum logic [1:0]
  {
    LINK_IDLE = 2'b01,
    LINK_WAIT = 2'b10
  } link_state_t;

  // Hysteresis selection codes
  typedef enum logic [1:0]
  {
    HYST_OFF = 2'b00,
    HYST_1P5 = 2'b01,
    HYST_3P0 = 2'b10,
    HYST_6P0 = 2'b11
  } hyst_sel_t;

  typedef logic [15:0] reg_word_t;
  typedef logic [10:0] limit_val_t;

endpackage

// file: verilog/thermal_threshold.sv
// One temperature threshold comparator with hysteresis.
// Assumes temperature and limit are B12..B2 two's complement words on clk_in.
`timescale 1ns/10ps
`default_nettype none

module thermal_threshold
(
  // Clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  // Sample and settings
  input  wire logic                          sample_in,
  input  wire logic                          below_mode_in,
  input  wire thermal_alert_pkg::limit_val_t temp_in,
  input  wire thermal_alert_pkg::limit_val_t limit_in,
  input  wire logic [4:0]                    hyst_in,
  // Condition flag
  output logic                               flag_out
);
  import thermal_alert_pkg::*;

  logic signed [11:0] temp_ext;
  logic signed [11:0] lim_ext;
  logic signed [11:0] lim_hyst;

  // Sign-extend so that limit minus hysteresis cannot wrap
  assign temp_ext = {temp_in[10], temp_in};
  assign lim_ext  = {limit_in[10], limit_in};
  assign lim_hyst = lim_ext - $signed({7'h00, hyst_in});

  // Above: set past limit, release at or below limit minus hysteresis; below: set under limit minus hysteresis, release at limit
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      flag_out <= 1'b0;
    else if (sample_in)
    begin
      if (below_mode_in)
        flag_out <= flag_out ? (temp_ext < lim_ext) : (temp_ext < lim_hyst);
      else
        flag_out <= flag_out ? (temp_ext > lim_hyst) : (temp_ext > lim_ext);
    end
  end

endmodule

`default_nettype wire

// file: verif/thermal_alert_config_chk.sv
// Assertion checker for the thermal alert block.
// Assumes it is bound to the block top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "thermal_alert_regs.svh"

module thermal_alert_config_chk
(
  // Clocks and resets
  input wire logic                         clk_in,
  input wire logic                         rst_in,
  input wire logic                         link_clk_in,
  input wire logic                         link_rst_in,
  // Register port
  input wire logic                         link_req_in,
  input wire logic                         link_write_in,
  input wire logic [3:0]                   link_addr_in,
  input wire thermal_alert_pkg::reg_word_t link_wdata_in,
  input wire logic                         link_busy_out,
  input wire logic                         link_rvalid_out,
  input wire thermal_alert_pkg::reg_word_t link_rdata_out,
  // Converter and pin
  input wire logic [12:0]                  temp_in,
  input wire logic                         temp_valid_in,
  input wire logic                         conv_enable_out,
  input wire logic                         alert_out
);
  import thermal_alert_pkg::*;

  logic [3:0] last_addr;

  // Pointer of the request in flight
  always_ff @(posedge link_clk_in)
  begin
    if (link_req_in && !link_busy_out)
    begin
      last_addr <= link_addr_in;
    end
  end

  sequence s_take;
    link_req_in && !link_busy_out;
  endsequence

  sequence s_done;
    ##[1:8] !link_busy_out;
  endsequence

  AST_BUSY_TAKE: assert property (@(posedge link_clk_in) disable iff (link_rst_in)
    s_take |=> link_busy_out) else $error("busy not raised after request");
  AST_BUSY_END: assert property (@(posedge link_clk_in) disable iff (link_rst_in)
    s_take |=> s_done) else $error("request not answered");
  AST_READ_ANS: assert property (@(posedge link_clk_in) disable iff (link_rst_in)
    s_take ##0 !link_write_in |-> ##[2:9] link_rvalid_out) else $error("read without data");
  AST_RVALID_BUSY: assert property (@(posedge link_clk_in) disable iff (link_rst_in)
    $rose(link_rvalid_out) |-> $fell(link_busy_out)) else $error("read data off the busy edge");
  AST_RDATA_HOLD: assert property (@(posedge link_clk_in) disable iff (link_rst_in)
    !link_rvalid_out |-> $stable(link_rdata_out)) else $error("read data moved");
  AST_CTRL_ZERO: assert property (@(posedge link_clk_in) disable iff (link_rst_in)
    link_rvalid_out && last_addr == `TA_OFF_CONTROL |-> link_rdata_out[15:11] == 5'h00 && !link_rdata_out[5])
    else $error("control read shows set reserved or clear bits");
  AST_LIMIT_GRAIN: assert property (@(posedge link_clk_in) disable iff (link_rst_in)
    link_rvalid_out && last_addr inside {[4'h2:4'h4]} |-> (link_rdata_out & ~`TA_LIMIT_MASK) == 16'h0000)
    else $error("limit read shows bits outside the grain");
  AST_UNMAPPED: assert property (@(posedge link_clk_in) disable iff (link_rst_in)
    link_rvalid_out && (last_addr == 4'h0 || last_addr > 4'h5) |-> link_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  AST_RESET_PIN: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(rst_in) |-> alert_out && conv_enable_out) else $error("pin or converter wrong after reset");
endmodule
`default_nettype wire

// file: verif/link_host_model.sv
// Host model issuing register requests on the link clock.
// Assumes one request at a time, answered by busy falling or a read pulse.
`timescale 1ns/10ps
`default_nettype none
`include "thermal_alert_regs.svh"

module link_host_model
(
  // Link clock and answer
  input wire logic                         link_clk_in,
  input wire logic                         busy_in,
  input wire logic                         rvalid_in,
  input wire thermal_alert_pkg::reg_word_t rdata_in,
  // Request
  output logic                             req_out,
  output logic                             write_out,
  output logic [3:0]                       addr_out,
  output thermal_alert_pkg::reg_word_t     wdata_out
);
  import thermal_alert_pkg::*;

  int   gap = 0;
  logic loose = 1'b0;
  logic hung = 1'b0;

  // Idle lines at time zero
  initial
  begin
    req_out = 1'b0;
    write_out = 1'b0;
    addr_out = 4'h0;
    wdata_out = 16'h0000;
  end

  // Holds the request through the taking edge, then waits a bounded time
  task automatic xfer(input logic wr, input logic [3:0] a, input reg_word_t d, output reg_word_t q);
    int n;
    repeat (gap + 1) @(posedge link_clk_in);
    #1;
    if (!loose && wr && a >= 4'h2 && a <= 4'h4)
    begin
      d = d & `TA_LIMIT_MASK;
      d[2] = 1'b0;
    end
    req_out = 1'b1;
    write_out = wr;
    addr_out = a;
    wdata_out = d;
    @(posedge link_clk_in);
    #1;
    req_out = 1'b0;
    write_out = ~wr;
    addr_out = ~a;
    wdata_out = ~d;
    n = 0;
    while (n < 20 && (wr ? busy_in : !rvalid_in))
    begin
      @(posedge link_clk_in);
      #1;
      n++;
    end
    if (n == 20)
      hung = 1'b1;
    q = rdata_in;
  endtask
endmodule
`default_nettype wire

// file: verif/thermal_alert_config_logic_bench.sv
// Self-checking bench of the thermal alert block.
// Assumes the host model drives the link port and the bench the converter.
`timescale 1ns/10ps
`default_nettype none

module thermal_alert_config_logic_bench;
  import thermal_alert_pkg::*;

  typedef struct packed {logic [3:0] a; reg_word_t w; reg_word_t e;} row_t;

  logic       clk_in = 1'b0;
  logic       link_clk_in = 1'b0;
  logic       rst_in;
  logic       link_rst_in;
  logic       link_req_in;
  logic       link_write_in;
  logic [3:0] link_addr_in;
  reg_word_t  link_wdata_in;
  logic       link_busy_out;
  logic       link_rvalid_out;
  reg_word_t  link_rdata_out;
  logic [12:0] temp_in;
  logic       temp_valid_in;
  logic       conv_enable_out;
  logic       alert_out;
  int         fails = 0;
  int         n_compared = 0;
  row_t       rows [9] = '{{4'h1, 16'hf83f, 16'h000f}, {4'h1, 16'h0200, 16'h0200},
    {4'h1, 16'h0400, 16'h0400}, {4'h1, 16'h0600, 16'h0600}, {4'h1, 16'h0000, 16'h0000},
    {4'h2, 16'hffff, 16'h1ffc}, {4'h3, 16'h0190, 16'h0190}, {4'h4, 16'h0640, 16'h0640},
    {4'h7, 16'h1234, 16'h0000}};

  // Core clock and unrelated link clock
  always #2 clk_in = ~clk_in;
  initial
  begin
    #7;
    forever #24 link_clk_in = ~link_clk_in;
  end

  thermal_alert_config_logic u_dut (.clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk_in),
    .link_rst_in(link_rst_in), .link_req_in(link_req_in), .link_write_in(link_write_in),
    .link_addr_in(link_addr_in), .link_wdata_in(link_wdata_in), .link_busy_out(link_busy_out),
    .link_rvalid_out(link_rvalid_out), .link_rdata_out(link_rdata_out), .temp_in(temp_in),
    .temp_valid_in(temp_valid_in), .conv_enable_out(conv_enable_out), .alert_out(alert_out));

  link_host_model u_host (.link_clk_in(link_clk_in), .busy_in(link_busy_out), .rvalid_in(link_rvalid_out),
    .rdata_in(link_rdata_out), .req_out(link_req_in), .write_out(link_write_in), .addr_out(link_addr_in),
    .wdata_out(link_wdata_in));

  task automatic check(input string what, input reg_word_t exp, input reg_word_t got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input reg_word_t d);
    reg_word_t q;
    u_host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, input reg_word_t e);
    reg_word_t q;
    u_host.xfer(1'b0, a, 16'h0000, q);
    check($sformatf("register %h", a), e, q);
  endtask

  // One converter sample, then time for the pin to settle
  task automatic temp(input logic [12:0] t);
    @(posedge clk_in);
    #1;
    temp_in = t;
    temp_valid_in = 1'b1;
    @(posedge clk_in);
    #1;
    temp_valid_in = 1'b0;
    repeat (4) @(posedge clk_in);
  endtask

  task automatic pin(input logic e);
    repeat (3) @(posedge clk_in);
    #1;
    check("alert_out", {15'h0000, e}, {15'h0000, alert_out});
  endtask

  task automatic stop_test;
    if (u_host.hung)
      fails++;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    #100000;
    fails++;
    stop_test();
  end

  initial
  begin
    rst_in = 1'b1;
    link_rst_in = 1'b1;
    temp_in = 13'h0000;
    temp_valid_in = 1'b0;
    repeat (10) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    repeat (3) @(posedge link_clk_in);
    #1;
    link_rst_in = 1'b0;
    repeat (3) @(posedge link_clk_in);
    pin(1'b1);
    check("conv_enable_out", 16'h0001, {15'h0000, conv_enable_out});
    rd(4'h1, 16'h0000);
    // Table of plain writes and read-backs
    u_host.loose = 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    u_host.loose = 1'b0;
    u_host.gap = 3;
    // Comparator mode with hysteresis on the upper limit
    wr(4'h2, 16'h0320);
    wr(4'h1, 16'h0208);
    temp(13'h0323);
    rd(4'h5, 16'h0323);
    pin(1'b1);
    temp(13'h0330);
    rd(4'h5, 16'h4330);
    rd(4'h1, 16'h0218);
    pin(1'b0);
    temp(13'h0310);
    pin(1'b0);
    temp(13'h0308);
    pin(1'b1);
    temp(13'h0330);
    wr(4'h1, 16'h020a);
    pin(1'b1);
    wr(4'h1, 16'h022a);
    pin(1'b1);
    wr(4'h1, 16'h0202);
    pin(1'b0);
    rd(4'h1, 16'h0202);
    // Interrupt mode latch and clear
    wr(4'h1, 16'h0209);
    temp(13'h0280);
    pin(1'b0);
    temp(13'h0330);
    pin(1'b0);
    temp(13'h0280);
    pin(1'b0);
    wr(4'h1, 16'h0229);
    pin(1'b1);
    rd(4'h1, 16'h0209);
    // Critical only, critical hysteresis
    wr(4'h1, 16'h020c);
    temp(13'h0330);
    pin(1'b1);
    temp(13'h0650);
    pin(1'b0);
    rd(4'h5, 16'hc650);
    temp(13'h0630);
    pin(1'b0);
    temp(13'h0628);
    pin(1'b1);
    // Lower limit, then a negative limit
    wr(4'h1, 16'h0208);
    temp(13'h0170);
    pin(1'b0);
    temp(13'h0188);
    pin(1'b0);
    temp(13'h0190);
    pin(1'b1);
    wr(4'h3, 16'h1fc0);
    temp(13'h1f80);
    pin(1'b0);
    temp(13'h0280);
    pin(1'b1);
    // Shutdown freezes the sample
    wr(4'h1, 16'h0308);
    check("conv_enable_out", 16'h0000, {15'h0000, conv_enable_out});
    temp(13'h0330);
    rd(4'h5, 16'h0280);
    pin(1'b1);
    // Locks
    wr(4'h1, 16'h03c8);
    rd(4'h1, 16'h03c8);
    wr(4'h1, 16'h02c8);
    rd(4'h1, 16'h02c8);
    wr(4'h1, 16'h0715);
    rd(4'h1, 16'h02c8);
    wr(4'h1, 16'h0008);
    rd(4'h1, 16'h02c8);
    wr(4'h2, 16'h0100);
    rd(4'h2, 16'h0320);
    wr(4'h4, 16'h0100);
    rd(4'h4, 16'h0640);
    // Power-on reset in mid-run releases the locks
    @(posedge clk_in);
    #1;
    rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    rd(4'h1, 16'h0000);
    wr(4'h2, 16'h0100);
    rd(4'h2, 16'h0100);
    stop_test();
  end
endmodule

bind thermal_alert_config_logic thermal_alert_config_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .link_clk_in(link_clk_in), .link_rst_in(link_rst_in), .link_req_in(link_req_in),
  .link_write_in(link_write_in), .link_addr_in(link_addr_in), .link_wdata_in(link_wdata_in),
  .link_busy_out(link_busy_out), .link_rvalid_out(link_rvalid_out), .link_rdata_out(link_rdata_out),
  .temp_in(temp_in), .temp_valid_in(temp_valid_in), .conv_enable_out(conv_enable_out), .alert_out(alert_out));
`default_nettype wire
